// ---- design/memory_map_bank_decoder.sv ----
`timescale 1ns/1ps
module memory_map_bank_decoder
  import memory_map_pkg::*;
#(
  parameter bit LARGE_PROGRAM = 1'b1
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire data_req_t data_req_i,
  input wire logic int_take_i,
  input wire logic jump_i,
  input wire logic [PC_W-1:0] jump_target_i,
  input wire logic [7:0] per_rdata_i,
  output logic [PC_W-1:0] fetch_addr_o,
  output phase_t phase_o,
  output logic [7:0] rdata_o,
  output logic [7:0] core_flags_o,
  output logic [7:0] resolved_addr_o,
  output logic unimpl_access_o,
  output per_req_t per_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam logic [PC_W-1:0] PROG_MASK =
    LARGE_PROGRAM ? LARGE_PROG_MASK : SMALL_PROG_MASK;

  phase_t phase_q;
  phase_t phase_d;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pc_d;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] pointer_q;
  logic [7:0] pointer_d;
  logic [4:0] pc_upper_q;
  logic [4:0] pc_upper_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [7:0] resolved_q;
  logic [7:0] resolved_d;
  logic unimpl_q;
  logic unimpl_d;
  per_req_t per_q;
  per_req_t per_d;

  logic [7:0] gpr0_q [GPR0_DEPTH];
  logic [7:0] gpr1_q [GPR1_DEPTH];

  // ----------------------------------------
  // address resolution
  // ----------------------------------------
  logic indirect;
  logic [7:0] full_addr;
  logic [6:0] rel;
  logic bank1;
  target_t tgt;
  logic [6:0] gpr_idx;

  always_comb begin
    indirect = (data_req_i.file == INDIRECT_ACCESS_PORT_ADDR[6:0]);
    if (indirect) begin
      full_addr = pointer_q;
    end else begin
      full_addr = {flags_q[BANK_SEL_BIT], data_req_i.file};
    end
    rel = full_addr[6:0];
    bank1 = full_addr[7];
    gpr_idx = rel - GPR_FIRST;
    tgt = T_NONE;
    if (rel >= COMMON_FIRST) begin
      // both banks land in bank 0 RAM here
      tgt = T_GPR0;
    end else if (rel >= GPR_FIRST) begin
      if (bank1) begin
        tgt = T_GPR1;
      end else begin
        tgt = T_GPR0;
      end
    end else begin
      case (rel)
        PROGRAM_COUNTER_LOW_ADDR[6:0]: begin
          tgt = T_PC_LOW;
        end
        CORE_FLAGS_ADDR[6:0]: begin
          tgt = T_FLAGS;
        end
        INDIRECT_POINTER_ADDR[6:0]: begin
          tgt = T_POINTER;
        end
        PC_UPPER_LATCH_ADDR[6:0]: begin
          tgt = T_PC_UPPER;
        end
        INTERRUPT_CONTROL_ADDR[6:0]: begin
          tgt = T_PERIPH;
        end
        default: begin
          case (full_addr)
            TIMER_COUNT_ADDR,
            PIN_PORT_DATA_ADDR,
            PERIPHERAL_INT_FLAGS_ADDR,
            CONVERSION_RESULT_ADDR,
            CONVERTER_CONTROL_ADDR,
            PRESCALER_CONFIG_ADDR,
            PIN_DIRECTION_ADDR,
            PERIPHERAL_INT_ENABLES_ADDR,
            POWER_RESET_FLAGS_ADDR,
            OSC_TRIM_ADDR,
            CONVERTER_CONFIG_ADDR: begin
              tgt = T_PERIPH;
            end
            default: begin
              // includes the pointer aimed at the port itself
              tgt = T_NONE;
            end
          endcase
        end
      endcase
    end
  end

  // ----------------------------------------
  // read data mux
  // ----------------------------------------
  logic [7:0] rd_val;
  logic [7:0] per_addr;

  always_comb begin
    per_addr = full_addr;
    if (rel == INTERRUPT_CONTROL_ADDR[6:0]) begin
      // the mirror is one register, so the peripheral sees one address
      per_addr = INTERRUPT_CONTROL_ADDR;
    end
    case (tgt)
      T_PC_LOW: begin
        rd_val = pc_q[7:0];
      end
      T_FLAGS: begin
        rd_val = flags_q;
      end
      T_POINTER: begin
        rd_val = pointer_q;
      end
      T_PC_UPPER: begin
        rd_val = {3'h0, pc_upper_q};
      end
      T_GPR0: begin
        rd_val = gpr0_q[gpr_idx];
      end
      T_GPR1: begin
        rd_val = gpr1_q[gpr_idx];
      end
      T_PERIPH: begin
        rd_val = per_rdata_i;
      end
      default: begin
        rd_val = DATA_ZERO;
      end
    endcase
  end

  // ----------------------------------------
  // quarter phases and data path
  // ----------------------------------------
  logic wr_now;

  always_comb begin
    case (phase_q)
      PH_Q1: begin
        phase_d = PH_Q2;
      end
      PH_Q2: begin
        phase_d = PH_Q3;
      end
      PH_Q3: begin
        phase_d = PH_Q4;
      end
      PH_Q4: begin
        phase_d = PH_Q1;
      end
      default: begin
        phase_d = PH_Q1;
      end
    endcase
    wr_now = (phase_q == PH_Q4) && data_req_i.wr;
    rdata_d = rdata_q;
    resolved_d = resolved_q;
    unimpl_d = unimpl_q;
    if (phase_q == PH_Q2) begin
      rdata_d = rd_val;
      resolved_d = full_addr;
      unimpl_d = (tgt == T_NONE);
    end
    flags_d = flags_q;
    pointer_d = pointer_q;
    pc_upper_d = pc_upper_q;
    if (wr_now) begin
      case (tgt)
        T_FLAGS: begin
          flags_d = data_req_i.wdata;
        end
        T_POINTER: begin
          pointer_d = data_req_i.wdata;
        end
        T_PC_UPPER: begin
          pc_upper_d = data_req_i.wdata[PC_UPPER_W-1:0];
        end
        default: begin
          // writes to unimplemented locations are dropped
          flags_d = flags_q;
        end
      endcase
    end
    per_d.addr = per_addr;
    per_d.wdata = data_req_i.wdata;
    per_d.rd = (phase_d == PH_Q2) && (tgt == T_PERIPH);
    per_d.wr = (phase_d == PH_Q4) && data_req_i.wr && (tgt == T_PERIPH);
  end

  // ----------------------------------------
  // program counter
  // ----------------------------------------
  always_comb begin
    pc_d = pc_q;
    if (phase_q == PH_Q4) begin
      // the interrupt wins, then a computed jump, then a branch, then a step
      if (int_take_i) begin
        pc_d = INT_VECTOR;
      end else if (wr_now && tgt == T_PC_LOW) begin
        pc_d = {pc_upper_q, data_req_i.wdata} & PROG_MASK;
      end else if (jump_i) begin
        pc_d = jump_target_i & PROG_MASK;
      end else begin
        pc_d = (pc_q + PC_STEP) & PROG_MASK;
      end
    end
  end

  // ----------------------------------------
  // general purpose RAM write enables
  // ----------------------------------------
  logic gpr0_we;
  logic gpr1_we;

  always_comb begin
    gpr0_we = wr_now && (tgt == T_GPR0);
    gpr1_we = wr_now && (tgt == T_GPR1);
  end

  // no reset on the ram contents: static ram powers up unknown
  always_ff @(posedge clock_i) begin
    if (gpr0_we) begin
      gpr0_q[gpr_idx] <= data_req_i.wdata;
    end
    if (gpr1_we) begin
      gpr1_q[gpr_idx] <= data_req_i.wdata;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_q <= PH_Q1;
      pc_q <= RESET_VECTOR;
      flags_q <= CORE_FLAGS_RST;
      pointer_q <= INDIRECT_POINTER_RST;
      pc_upper_q <= PC_UPPER_RST;
      rdata_q <= DATA_ZERO;
      resolved_q <= DATA_ZERO;
      unimpl_q <= 1'b0;
      per_q <= '0;
    end else begin
      phase_q <= phase_d;
      pc_q <= pc_d;
      flags_q <= flags_d;
      pointer_q <= pointer_d;
      pc_upper_q <= pc_upper_d;
      rdata_q <= rdata_d;
      resolved_q <= resolved_d;
      unimpl_q <= unimpl_d;
      per_q <= per_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  always_comb begin
    fetch_addr_o = pc_q;
    phase_o = phase_q;
    rdata_o = rdata_q;
    core_flags_o = flags_q;
    resolved_addr_o = resolved_q;
    unimpl_access_o = unimpl_q;
    per_o = per_q;
  end

endmodule

// ---- design/memory_map_pkg.sv ----
package memory_map_pkg;

  // ----------------------------------------
  // program side
  // ----------------------------------------
  localparam int PC_W = 13;
  localparam int PROG_SPACE_WORDS = 8192;
  localparam int INSTR_W = 14;
  localparam logic [12:0] SMALL_PROG_MASK = 13'h03FF;
  localparam logic [12:0] LARGE_PROG_MASK = 13'h07FF;
  localparam logic [12:0] RESET_VECTOR = 13'h0000;
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  localparam logic [12:0] PC_STEP = 13'h0001;
  localparam int PC_UPPER_W = 5;

  // ----------------------------------------
  // data side layout
  // ----------------------------------------
  localparam int FILE_W = 7;
  localparam int BANK_SEL_BIT = 5;
  localparam logic [6:0] BANK_LAST = 7'h7F;
  localparam logic [6:0] GPR_FIRST = 7'h20;
  localparam logic [6:0] GPR1_LAST = 7'h6F;
  localparam logic [6:0] COMMON_FIRST = 7'h70;
  localparam int GPR0_DEPTH = 96;
  localparam int GPR1_DEPTH = 80;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] INDIRECT_ACCESS_PORT_ADDR = 8'h00;
  localparam logic [7:0] TIMER_COUNT_ADDR = 8'h01;
  localparam logic [7:0] PROGRAM_COUNTER_LOW_ADDR = 8'h02;
  localparam logic [7:0] CORE_FLAGS_ADDR = 8'h83;
  localparam logic [7:0] INDIRECT_POINTER_ADDR = 8'h84;
  localparam logic [7:0] PIN_PORT_DATA_ADDR = 8'h05;
  localparam logic [7:0] PC_UPPER_LATCH_ADDR = 8'h0A;
  localparam logic [7:0] INTERRUPT_CONTROL_ADDR = 8'h0B;
  localparam logic [7:0] PERIPHERAL_INT_FLAGS_ADDR = 8'h0C;
  localparam logic [7:0] CONVERSION_RESULT_ADDR = 8'h1E;
  localparam logic [7:0] CONVERTER_CONTROL_ADDR = 8'h1F;
  localparam logic [7:0] PRESCALER_CONFIG_ADDR = 8'h81;
  localparam logic [7:0] PIN_DIRECTION_ADDR = 8'h85;
  localparam logic [7:0] PERIPHERAL_INT_ENABLES_ADDR = 8'h8C;
  localparam logic [7:0] POWER_RESET_FLAGS_ADDR = 8'h8E;
  localparam logic [7:0] OSC_TRIM_ADDR = 8'h8F;
  localparam logic [7:0] CONVERTER_CONFIG_ADDR = 8'h9F;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CORE_FLAGS_RST = 8'h18;
  localparam logic [7:0] INDIRECT_POINTER_RST = 8'h00;
  localparam logic [4:0] PC_UPPER_RST = 5'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

  typedef enum logic [2:0] {
    T_NONE, T_PC_LOW, T_FLAGS, T_POINTER, T_PC_UPPER, T_GPR0, T_GPR1, T_PERIPH
  } target_t;

  typedef struct packed {
    logic [6:0] file;
    logic wr;
    logic [7:0] wdata;
  } data_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } per_req_t;

endpackage

// ---- design/unused_placeholder_removed.sv ----
`timescale 1ns/1ps

// ---- test/memory_map_bank_decoder_sva.sv ----
`timescale 1ns/1ps
module memory_map_bank_decoder_sva
  import memory_map_pkg::*;
#(
  parameter bit LARGE_PROGRAM = 1'b1
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire data_req_t data_req_i,
  input wire logic int_take_i,
  input wire logic jump_i,
  input wire logic [PC_W-1:0] jump_target_i,
  input wire logic [7:0] per_rdata_i,
  input wire logic [PC_W-1:0] fetch_addr_o,
  input wire phase_t phase_o,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] core_flags_o,
  input wire logic [7:0] resolved_addr_o,
  input wire logic unimpl_access_o,
  input wire per_req_t per_o
);
  localparam logic [12:0] MASK = LARGE_PROGRAM ? LARGE_PROG_MASK : SMALL_PROG_MASK;
  logic [7:0] direct_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  // direct address as the decoder should have formed it at the operand edge
  always_ff @(posedge clock_i) direct_q <= {core_flags_o[BANK_SEL_BIT], data_req_i.file};
  chk_phase_step: assert property (phase_o == PH_Q1 |=> phase_o == PH_Q2)
    else $error("phase did not step from Q1 to Q2");
  chk_pc_range: assert property ((fetch_addr_o & ~MASK) == 13'h0000)
    else $error("fetch address outside implemented memory");
  chk_reset_vec: assert property ($rose(reset_n_i) |-> fetch_addr_o == RESET_VECTOR)
    else $error("fetch address not at reset vector");
  chk_int_vec: assert property (phase_o == PH_Q4 && int_take_i |=> fetch_addr_o == INT_VECTOR)
    else $error("interrupt did not load the vector");
  chk_pc_hold: assert property (phase_o != PH_Q4 |=> $stable(fetch_addr_o))
    else $error("fetch address moved outside Q4 end");
  chk_rd_q2: assert property (per_o.rd |-> phase_o == PH_Q2)
    else $error("peripheral read outside Q2");
  chk_wr_q4: assert property (per_o.wr |-> phase_o == PH_Q4)
    else $error("peripheral write outside Q4");
  chk_unimpl_zero: assert property (unimpl_access_o |-> rdata_o == DATA_ZERO)
    else $error("unimplemented location read nonzero");
  chk_rdata_hold: assert property (phase_o != PH_Q2 |=> $stable(rdata_o))
    else $error("operand changed outside Q2 end");
  chk_direct_addr: assert property (phase_o == PH_Q2 && data_req_i.file != 7'h00
    |=> resolved_addr_o == direct_q)
    else $error("direct address not bank bit over file field");
  cov_int: cover property (phase_o == PH_Q4 && int_take_i);
  cov_per_wr: cover property (per_o.wr);
  cov_unimpl: cover property (unimpl_access_o);
endmodule

bind memory_map_bank_decoder memory_map_bank_decoder_sva #(.LARGE_PROGRAM(LARGE_PROGRAM))
  memory_map_bank_decoder_sva_i (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .data_req_i(data_req_i), .int_take_i(int_take_i), .jump_i(jump_i),
  .jump_target_i(jump_target_i), .per_rdata_i(per_rdata_i), .fetch_addr_o(fetch_addr_o),
  .phase_o(phase_o), .rdata_o(rdata_o), .core_flags_o(core_flags_o),
  .resolved_addr_o(resolved_addr_o), .unimpl_access_o(unimpl_access_o), .per_o(per_o));

// ---- test/peripheral_responder.sv ----
`timescale 1ns/1ps
module peripheral_responder
  import memory_map_pkg::*;
(
  input wire logic clock_i,
  input wire per_req_t per_i,
  output logic [7:0] per_rdata_o
);
  logic [7:0] noise_q = 8'hA5;
  logic [7:0] noise_d;
  always_comb noise_d = noise_q + 8'h01;
  always_ff @(posedge clock_i) noise_q <= noise_d;
  // off the read strobe the bus wanders, so a late sample never looks right
  always_comb per_rdata_o = per_i.rd ? (per_i.addr ^ 8'h5A) : noise_q;
endmodule

// ---- test/memory_map_bank_decoder_tb.sv ----
`timescale 1ns/1ps
module memory_map_bank_decoder_tb;
  import memory_map_pkg::*;
  logic clock_i;
  logic reset_n_i;
  data_req_t data_req_i;
  logic int_take_i;
  logic jump_i;
  logic [PC_W-1:0] jump_target_i;
  logic [7:0] per_rdata_i;
  logic [PC_W-1:0] fetch_addr_o;
  logic [PC_W-1:0] fetch_small;
  phase_t phase_o;
  logic [7:0] rdata_o;
  logic [7:0] core_flags_o;
  logic unimpl_access_o;
  logic [7:0] resolved_addr_o;
  per_req_t per_o;
  int n_errors;
  int num_checks;
  logic [9:0] notes[$];
  logic [7:0] v0, v1, v2, v3;
  memory_map_bank_decoder #(.LARGE_PROGRAM(1'b1)) memory_map_bank_decoder_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .data_req_i(data_req_i),
    .int_take_i(int_take_i), .jump_i(jump_i), .jump_target_i(jump_target_i),
    .per_rdata_i(per_rdata_i), .fetch_addr_o(fetch_addr_o), .phase_o(phase_o),
    .rdata_o(rdata_o), .core_flags_o(core_flags_o), .resolved_addr_o(resolved_addr_o),
    .unimpl_access_o(unimpl_access_o), .per_o(per_o));
  memory_map_bank_decoder #(.LARGE_PROGRAM(1'b0)) memory_map_bank_decoder_small_i (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .data_req_i(data_req_i),
    .int_take_i(int_take_i), .jump_i(jump_i), .jump_target_i(jump_target_i),
    .per_rdata_i(per_rdata_i), .fetch_addr_o(fetch_small), .phase_o(), .rdata_o(),
    .core_flags_o(), .resolved_addr_o(), .unimpl_access_o(), .per_o());
  peripheral_responder peripheral_responder_i (.clock_i(clock_i), .per_i(per_o),
    .per_rdata_o(per_rdata_i));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one instruction cycle; note bit 9 marks an operand that cannot be predicted
  task automatic instr(input logic [6:0] a, input logic [7:0] wd, input logic w,
                       input logic ik, input logic jp, input logic [9:0] note);
    int k;
    k = 0;
    while (phase_o !== PH_Q1 && k < 8) begin
      @(negedge clock_i);
      k++;
    end
    if (k == 8) begin
      n_errors++;
      wrap_up();
    end
    data_req_i = '{file: a, wr: w, wdata: wd};
    int_take_i = ik;
    jump_i = jp;
    notes.push_back(note);
    repeat (4) @(negedge clock_i);
  endtask
  // ----------------------------------------
  // clock, result watcher, sequence
  // ----------------------------------------
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  initial begin
    logic [9:0] e;
    forever begin
      @(negedge clock_i);
      if (phase_o === PH_Q3 && notes.size() > 0) begin
        e = notes.pop_front();
        if (e[9] === 1'b0) chk({unimpl_access_o, rdata_o}, e[8:0]);
      end
    end
  end
  initial begin
    n_errors = 0;
    num_checks = 0;
    reset_n_i = 1'b0;
    int_take_i = 1'b0;
    jump_i = 1'b0;
    jump_target_i = 13'h1FFF;
    data_req_i = '{file: 7'h07, wr: 1'b0, wdata: 8'h00};
    void'($urandom(32'hced24a93));
    v0 = 8'($urandom);
    v1 = 8'($urandom);
    v2 = 8'($urandom);
    v3 = 8'($urandom);
    repeat (12) @(negedge clock_i);
    reset_n_i = 1'b1;
    chk(fetch_addr_o, RESET_VECTOR);
    chk(core_flags_o, CORE_FLAGS_RST);
    instr(7'h20, v0, 1, 0, 0, 10'h200);
    instr(7'h03, 8'h38, 1, 0, 0, 10'h018);
    chk(core_flags_o[5], 1'b1);
    instr(7'h20, v1, 1, 0, 0, 10'h200);
    instr(7'h20, 8'h00, 0, 0, 0, {2'b00, v1});
    chk(resolved_addr_o, 8'hA0);
    instr(7'h70, v2, 1, 0, 0, 10'h200);
    instr(7'h0B, 8'h00, 0, 0, 0, 10'h051);
    instr(7'h06, 8'h00, 0, 0, 0, 10'h100);
    instr(7'h04, 8'hA0, 1, 0, 0, 10'h200);
    instr(7'h00, 8'h00, 0, 0, 0, {2'b00, v1});
    chk(resolved_addr_o, 8'hA0);
    instr(7'h03, 8'h18, 1, 0, 0, 10'h200);
    chk(core_flags_o[5], 1'b0);
    instr(7'h20, 8'h00, 0, 0, 0, {2'b00, v0});
    instr(7'h70, 8'h00, 0, 0, 0, {2'b00, v2});
    instr(7'h01, 8'h00, 0, 0, 0, 10'h05B);
    instr(7'h05, v0, 1, 0, 0, 10'h05F);
    instr(7'h07, 8'hFF, 1, 0, 0, 10'h100);
    instr(7'h07, 8'h00, 0, 0, 0, 10'h100);
    instr(7'h04, 8'hF3, 1, 0, 0, 10'h200);
    instr(7'h00, v3, 1, 0, 0, 10'h200);
    chk(resolved_addr_o, 8'hF3);
    instr(7'h73, 8'h00, 0, 0, 0, {2'b00, v3});
    instr(7'h07, 8'h00, 0, 0, 1, 10'h100);
    chk(fetch_addr_o, 13'h07FF);
    chk(fetch_small, 13'h03FF);
    instr(7'h07, 8'h00, 0, 0, 0, 10'h100);
    chk(fetch_addr_o, RESET_VECTOR);
    chk(fetch_small, RESET_VECTOR);
    instr(7'h07, 8'h00, 0, 1, 1, 10'h100);
    chk(fetch_addr_o, INT_VECTOR);
    instr(7'h0A, 8'h1F, 1, 0, 0, 10'h200);
    instr(7'h02, 8'h34, 1, 0, 1, 10'h200);
    chk(fetch_addr_o, 13'h0734);
    chk(fetch_small, 13'h0334);
    repeat (4) @(negedge clock_i);
    wrap_up();
  end
endmodule
